// >>> hdl/hbp_device.sv
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "hbp_regs.svh"
module hbp_device (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // host link
    hbp_if.device            link,
    // core user side
    input  wire logic        irq_event_in,
    input  wire logic        maint_start_in,
    input  wire logic        cell_out_load_in,
    input  wire logic [31:0] cell_out_word_in,
    output logic             cell_in_full_out,
    output logic [31:0]      cell_in_word_out,
    input  wire logic        cell_in_take_in,
    output logic [31:0]      maint_word_out,
    output logic             maint_word_out_valid_out
);
    import hbp_pkg::*;

    logic [3:0]  bclk_sync_q;
    logic        bclk_fall;
    logic        sel_s1_q, sel_s2_q, rnw_s1_q, rnw_s2_q;
    logic        ds_s1_q, ds_s2_q, wsh_s1_q, wsh_s2_q, wsl_s1_q, wsl_s2_q;
    logic [23:0] addr_s1_q, addr_s2_q;
    logic [31:0] dat_s1_q, dat_s2_q;
    logic        acc_done_q;
    logic [31:0] cfg_q;
    logic [31:0] cell_in_q, cell_out_q, maint_q;
    logic        cell_out_ready_q, irq_q;
    logic [1:0]  ack_cnt_q;
    logic        ack_en_q;
    logic [7:0]  lead_cnt_q;
    logic        maint_req_q;
    logic [7:0]  nacc_q;
    logic [2:0]  req_q;
    logic [7:0]  idx;
    logic        wr_go, rd_go;
    hbp_lanes_type lanes;

    // lane decode shared by both write modes
    function automatic hbp_lanes_type lane_decode(input logic word_select_mode, input logic order,
                                                  input logic wsh, input logic wsl);
        if (!word_select_mode)
            lane_decode = {~wsh, ~wsl};
        else if (!wsl)
            lane_decode = 2'h3;
        else
            lane_decode = (wsh ^ order) ? 2'h1 : 2'h2;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input hbp_lanes_type ln);
        merge = {ln[1] ? nw[31:16] : old[31:16], ln[0] ? nw[15:0] : old[15:0]};
    endfunction

    // bus clock and pins pass two flops before use
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bclk_sync_q <= 4'h0;
            {sel_s1_q, sel_s2_q, rnw_s1_q, rnw_s2_q} <= 4'hf;
            {ds_s1_q, ds_s2_q, wsh_s1_q, wsh_s2_q, wsl_s1_q, wsl_s2_q} <= 6'h3f;
            addr_s1_q <= 24'h00_0000;
            addr_s2_q <= 24'h00_0000;
            dat_s1_q  <= 32'h0000_0000;
            dat_s2_q  <= 32'h0000_0000;
        end else begin
            bclk_sync_q <= {bclk_sync_q[2:0], link.bus_clk};
            sel_s1_q  <= link.host_select_n;
            sel_s2_q  <= sel_s1_q;
            rnw_s1_q  <= link.host_read_not_write;
            rnw_s2_q  <= rnw_s1_q;
            ds_s1_q   <= link.write_data_strobe;
            ds_s2_q   <= ds_s1_q;
            wsh_s1_q  <= link.high_word_write_en;
            wsh_s2_q  <= wsh_s1_q;
            wsl_s1_q  <= link.low_word_write_en;
            wsl_s2_q  <= wsl_s1_q;
            addr_s1_q <= link.addr;
            addr_s2_q <= addr_s1_q;
            dat_s1_q  <= link.host_data_bus;
            dat_s2_q  <= dat_s1_q;
        end
    end

    // falling edge seen on synchronised copies only
    assign bclk_fall = bclk_sync_q[2] & ~bclk_sync_q[1];
    assign idx       = addr_s2_q[7:0];
    // write commits only once the strobe marks data valid
    assign wr_go = bclk_fall & ~sel_s2_q & ~rnw_s2_q & ~ds_s2_q & ~acc_done_q;
    assign rd_go = bclk_fall & ~sel_s2_q & rnw_s2_q & ~acc_done_q;
    assign lanes = lane_decode(cfg_q[`HBP_CFG_WORD_SELECT_MODE_BIT], cfg_q[`HBP_CFG_ORDER_BIT],
                               wsh_s2_q, wsl_s2_q);

    // one completion per select window
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            acc_done_q <= 1'b0;
        else if (sel_s2_q)
            acc_done_q <= 1'b0;
        else if (wr_go || rd_go)
            acc_done_q <= 1'b1;
    end

    // config register, request functions and counts
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            cfg_q <= `HBP_CFG_RESET;
        else if (wr_go && idx == `HBP_IDX_CONFIG)
            cfg_q <= merge(cfg_q, dat_s2_q, lanes);
    end

    // insert array fills on write, frees when core takes it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cell_in_q <= 32'h0000_0000;
            cell_in_full_out <= 1'b0;
        end else if (wr_go && idx == `HBP_IDX_CELL_IN) begin
            cell_in_q <= merge(cell_in_q, dat_s2_q, lanes);
            cell_in_full_out <= 1'b1;
        end else if (cell_in_take_in) begin
            cell_in_full_out <= 1'b0;
        end
    end
    assign cell_in_word_out = cell_in_q;

    // extract array ready; a new load wins over the read
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cell_out_q <= 32'h0000_0000;
            cell_out_ready_q <= 1'b0;
        end else if (cell_out_load_in) begin
            cell_out_q <= cell_out_word_in;
            cell_out_ready_q <= 1'b1;
        end else if (rd_go && idx == `HBP_IDX_CELL_OUT) begin
            cell_out_ready_q <= 1'b0;
        end
    end

    // interrupt flag on core clock; set wins over clear-by-read
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            irq_q <= 1'b0;
        else if (irq_event_in)
            irq_q <= 1'b1;
        else if (rd_go && idx == `HBP_IDX_IRQ)
            irq_q <= 1'b0;
    end

    // maintenance request lead and access counting
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lead_cnt_q  <= 8'h00;
            maint_req_q <= 1'b0;
            nacc_q      <= 8'h00;
            maint_q     <= 32'h0000_0000;
            maint_word_out_valid_out <= 1'b0;
        end else begin
            maint_word_out_valid_out <= 1'b0;
            if (maint_start_in && !maint_req_q) begin
                // request precedes cycle start by lead count
                lead_cnt_q  <= cfg_q[`HBP_CFG_LEAD_LSB +: 8];
                maint_req_q <= 1'b1;
                nacc_q      <= 8'h00;
            end else if (lead_cnt_q != 8'h00) begin
                lead_cnt_q <= lead_cnt_q - 8'h01;
            end
            if (wr_go && idx == `HBP_IDX_MAINT_DATA) begin
                maint_q <= merge(maint_q, dat_s2_q, lanes);
                maint_word_out_valid_out <= 1'b1;
                if (maint_req_q) begin
                    nacc_q <= nacc_q + 8'h01;
                    if (nacc_q + 8'h01 >= cfg_q[`HBP_CFG_NACC_LSB +: 8])
                        maint_req_q <= 1'b0;
                end
            end
        end
    end
    assign maint_word_out = maint_q;

    // request pins update on bus clock falling edge only
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            req_q <= 3'h0;
        end else if (bclk_fall) begin
            for (int i = 0; i < 3; i++) begin
                case (cfg_q[`HBP_CFG_SEL0_LSB + 2*i +: 2])
                    HBP_FN_CELL_IN:  req_q[i] <= ~cell_in_full_out;
                    HBP_FN_CELL_OUT: req_q[i] <= cell_out_ready_q;
                    HBP_FN_MAINT:    req_q[i] <= maint_req_q;
                    default:         req_q[i] <= 1'b0;
                endcase
            end
        end
    end
    assign link.dma_req      = req_q;
    assign link.host_irq_out = irq_q;

    // ack pulse on core clock, free of bus clock
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_cnt_q <= 2'h0;
            ack_en_q  <= 1'b0;
        end else if (wr_go || rd_go) begin
            ack_cnt_q <= 2'(`HBP_ACK_CYCLES);
            ack_en_q  <= rd_go ? ~cfg_q[`HBP_CFG_NOACKR_BIT] : ~cfg_q[`HBP_CFG_NOACKW_BIT];
        end else if (ack_cnt_q != 2'h0) begin
            ack_cnt_q <= ack_cnt_q - 2'h1;
        end
    end
    assign link.ack_out = 2'h3;
    assign link.ack_oe  = {2{ack_en_q && ack_cnt_q != 2'h0}};

    // drive data only during a selected read
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            link.dev_data_out <= 32'h0000_0000;
        // hold the word once taken, so a clear-on-read returns the old value
        else if (!acc_done_q) begin
            case (idx)
                `HBP_IDX_CONFIG:     link.dev_data_out <= cfg_q;
                `HBP_IDX_STATUS:     link.dev_data_out <= {16'h0, lead_cnt_q, 4'h0,
                                                           maint_req_q, irq_q,
                                                           cell_out_ready_q, cell_in_full_out};
                `HBP_IDX_CELL_IN:    link.dev_data_out <= cell_in_q;
                `HBP_IDX_CELL_OUT:   link.dev_data_out <= cell_out_q;
                `HBP_IDX_MAINT_DATA: link.dev_data_out <= maint_q;
                `HBP_IDX_IRQ:        link.dev_data_out <= {31'h0, irq_q};
                default:             link.dev_data_out <= 32'h0000_0000;
            endcase
        end
    end
    // device half of the shared bus
    assign link.dev_data_oe = ~link.host_select_n & link.host_read_not_write;

endmodule // hbp_device

// >>> hdl/hbp_host.sv
`timescale 1ns/100ps
`include "hbp_regs.svh"
module hbp_host #(
    parameter int CLK_DIV = 4
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // link
    hbp_if.host              link
);
    import hbp_pkg::*;

    hbp_host_state_type state_q;
    logic [7:0]  div_q;
    logic        bclk_q, fall_en;
    logic [31:0] cmd_q, addr_q, wdata_q, rdata_q;
    logic        busy_q, go;
    logic [1:0]  ack_s_q, irq_s_q;
    logic [5:0]  req_s_q;
    logic        rd_hold_q;

    // bus clock divided from core clock
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_q  <= 8'h00;
            bclk_q <= 1'b0;
        end else if (div_q == 8'(CLK_DIV - 1)) begin
            div_q  <= 8'h00;
            bclk_q <= ~bclk_q;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    // next update is the edge where bus clock goes high; signals then stand for falling edge
    assign fall_en = (div_q == 8'(CLK_DIV - 1)) & ~bclk_q;

    // ack and status pins treated as asynchronous
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ack_s_q <= 2'h3;
            irq_s_q <= 2'h0;
            req_s_q <= 6'h00;
        end else begin
            ack_s_q <= {ack_s_q[0], &link.access_ack_outputs};
            irq_s_q <= {irq_s_q[0], link.host_irq_out};
            req_s_q <= {req_s_q[2:0], link.dma_req};
        end
    end

    assign go = avs_write_in && avs_address_in == `HBP_AV_CMD && !busy_q;
    assign avs_waitrequest_out = avs_read_in & ~rd_hold_q;

    // reads wait one cycle so registered data stands when wait drops
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            rd_hold_q <= 1'b0;
        else
            rd_hold_q <= avs_read_in & ~rd_hold_q;
    end

    // avalon registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_q   <= 32'h0000_0000;
            addr_q  <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
        end else if (avs_write_in) begin
            case (avs_address_in)
                `HBP_AV_CMD:   cmd_q   <= busy_q ? cmd_q : avs_writedata_in;
                `HBP_AV_ADDR:  addr_q  <= avs_writedata_in;
                `HBP_AV_WDATA: wdata_q <= avs_writedata_in;
                default:       cmd_q   <= cmd_q;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (avs_read_in) begin
            case (avs_address_in)
                `HBP_AV_CMD:    avs_readdata_out <= cmd_q;
                `HBP_AV_ADDR:   avs_readdata_out <= addr_q;
                `HBP_AV_WDATA:  avs_readdata_out <= wdata_q;
                `HBP_AV_RDATA:  avs_readdata_out <= rdata_q;
                `HBP_AV_STATUS: avs_readdata_out <= {27'h0, req_s_q[5:3], irq_s_q[1], busy_q};
                default:        avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // one access, changed only before falling edges; longword via cmd bits
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= HBP_H_IDLE;
            busy_q  <= 1'b0;
            rdata_q <= 32'h0000_0000;
            link.host_select_n       <= 1'b1;
            link.host_read_not_write <= 1'b1;
            link.write_data_strobe   <= 1'b1;
            link.high_word_write_en  <= 1'b1;
            link.low_word_write_en   <= 1'b1;
            link.addr                <= 24'h00_0000;
            link.host_data_out       <= 32'h0000_0000;
            link.host_data_oe        <= 1'b0;
        end else begin
            case (state_q)
                HBP_H_IDLE: if (go) begin
                    busy_q  <= 1'b1;
                    state_q <= HBP_H_SETUP;
                end
                HBP_H_SETUP: if (fall_en) begin
                    link.addr                <= addr_q[25:2];
                    link.host_read_not_write <= cmd_q[0];
                    link.high_word_write_en  <= cmd_q[1];
                    link.low_word_write_en   <= cmd_q[2];
                    link.host_data_out       <= wdata_q;
                    // host drives bus only on writes
                    link.host_data_oe        <= ~cmd_q[0];
                    link.write_data_strobe   <= cmd_q[0];
                    link.host_select_n       <= 1'b0;
                    state_q <= HBP_H_WAIT;
                end
                HBP_H_WAIT: if (ack_s_q[1] == 1'b1 && ack_s_q[0] == 1'b1 && fall_en) begin
                    rdata_q <= link.host_data_bus;
                    state_q <= HBP_H_END;
                end
                HBP_H_END: if (fall_en) begin
                    link.host_select_n     <= 1'b1;
                    link.write_data_strobe <= 1'b1;
                    link.host_data_oe      <= 1'b0;
                    busy_q  <= 1'b0;
                    state_q <= HBP_H_IDLE;
                end
                default: state_q <= HBP_H_IDLE;
            endcase
        end
    end
    assign link.bus_clk = bclk_q;

endmodule // hbp_host

// >>> hdl/hbp_if.sv
`timescale 1ns/100ps
interface hbp_if;
    logic        bus_clk;
    logic [23:0] addr;
    logic        host_select_n;
    logic        host_read_not_write;
    logic        write_data_strobe;
    logic        high_word_write_en;
    logic        low_word_write_en;
    logic [31:0] host_data_out;
    logic        host_data_oe;
    logic [31:0] dev_data_out;
    logic        dev_data_oe;
    logic [1:0]  ack_out;
    logic [1:0]  ack_oe;
    logic        host_irq_out;
    logic [2:0]  dma_req;
    logic [31:0] host_data_bus;
    logic [1:0]  access_ack_outputs;

    // wire resolution; a pulled-up ack reads high when nobody drives
    assign host_data_bus = dev_data_oe ? dev_data_out :
                           (host_data_oe ? host_data_out : 32'h0000_0000);
    assign access_ack_outputs[0] = ack_oe[0] ? ack_out[0] : 1'b1;
    assign access_ack_outputs[1] = ack_oe[1] ? ack_out[1] : 1'b1;

    modport device (
        input  bus_clk, addr, host_select_n, host_read_not_write,
        input  write_data_strobe, high_word_write_en, low_word_write_en,
        input  host_data_bus,
        output dev_data_out, dev_data_oe, ack_out, ack_oe, host_irq_out, dma_req
    );
    modport host (
        output bus_clk, addr, host_select_n, host_read_not_write,
        output write_data_strobe, high_word_write_en, low_word_write_en,
        output host_data_out, host_data_oe,
        input  host_data_bus, access_ack_outputs, host_irq_out, dma_req
    );
endinterface

// >>> hdl/hbp_pkg.sv
package hbp_pkg;
    typedef enum logic [1:0] {
        HBP_FN_CELL_IN  = 2'h0,
        HBP_FN_CELL_OUT = 2'h1,
        HBP_FN_MAINT    = 2'h2
    } hbp_req_fn_type;

    typedef enum logic [3:0] {
        HBP_H_IDLE  = 4'h1,
        HBP_H_SETUP = 4'h2,
        HBP_H_WAIT  = 4'h4,
        HBP_H_END   = 4'h8
    } hbp_host_state_type;

    typedef logic [1:0] hbp_lanes_type;
endpackage

// >>> hdl/hbp_regs.svh
`ifndef HBP_REGS_SVH
`define HBP_REGS_SVH

// register indices in the device's own space (word address bits [7:0])
`define HBP_IDX_CONFIG     8'h00
`define HBP_IDX_STATUS     8'h01
`define HBP_IDX_CELL_IN    8'h02
`define HBP_IDX_CELL_OUT   8'h03
`define HBP_IDX_MAINT_DATA 8'h04
`define HBP_IDX_IRQ        8'h05

// config register fields
`define HBP_CFG_WORD_SELECT_MODE_BIT   0
`define HBP_CFG_ORDER_BIT  1
`define HBP_CFG_NOACKW_BIT 2
`define HBP_CFG_NOACKR_BIT 3
`define HBP_CFG_SEL0_LSB   4
`define HBP_CFG_SEL1_LSB   6
`define HBP_CFG_SEL2_LSB   8
`define HBP_CFG_LEAD_LSB   12
`define HBP_CFG_NACC_LSB   20
`define HBP_CFG_RESET      32'h0010_4240

// host-side avalon register offsets
`define HBP_AV_CMD    4'h0
`define HBP_AV_ADDR   4'h1
`define HBP_AV_WDATA  4'h2
`define HBP_AV_RDATA  4'h3
`define HBP_AV_STATUS 4'h4

// ack pull-up pulse length in core cycles
`define HBP_ACK_CYCLES 2

`endif

// >>> verification/hbp_properties.sv
`timescale 1ns/100ps
module hbp_properties (
    // watched link signals
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       bus_clk,
    input wire logic       host_select_n,
    input wire logic       host_read_not_write,
    input wire logic       host_data_oe,
    input wire logic       dev_data_oe,
    input wire logic [1:0] ack_out,
    input wire logic [1:0] ack_oe,
    input wire logic       host_irq_out,
    input wire logic [2:0] dma_req,
    input wire logic       irq_event_in
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_oe_read;
        dev_data_oe |-> !host_select_n && host_read_not_write;
    endproperty
    a_oe_read: assert property (p_oe_read)
        else $error("data bus driven outside a read");
    property p_oe_release;
        $rose(host_select_n) |-> !dev_data_oe;
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("data bus held after deselect");
    property p_bus_single;
        !(dev_data_oe && host_data_oe);
    endproperty
    a_bus_single: assert property (p_bus_single)
        else $error("both ends drive the data bus");
    // synced fall lands a few cycles into the low phase
    property p_req_fall;
        $changed(dma_req) |-> !$past(bus_clk) || !$past(bus_clk, 2) || !$past(bus_clk, 3);
    endproperty
    a_req_fall: assert property (p_req_fall)
        else $error("request changed away from bus clock fall");
    property p_ack_pulse;
        $rose(ack_oe[0]) |-> ack_oe[0] ##1 ack_oe[0] ##1 !ack_oe[0];
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack drive not a two cycle pulse");
    property p_ack_high;
        |ack_oe |-> (ack_out & ack_oe) == ack_oe;
    endproperty
    a_ack_high: assert property (p_ack_high)
        else $error("ack driven low");
    property p_ack_sel;
        $rose(ack_oe[1]) |-> !host_select_n;
    endproperty
    a_ack_sel: assert property (p_ack_sel)
        else $error("ack outside an access");
    property p_irq_set;
        irq_event_in |-> ##[1:2] host_irq_out;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("interrupt not raised");
    property p_irq_cause;
        $rose(host_irq_out) |-> $past(irq_event_in) || $past(irq_event_in, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without event");

    c_ack: cover property ($rose(ack_oe[0]));
    c_read: cover property ($rose(dev_data_oe));
    c_maint: cover property ($rose(dma_req[2]));
endmodule // hbp_properties

// >>> verification/host_bus_port_dma_requests_tb.sv
`timescale 1ns/100ps
`include "hbp_regs.svh"
module host_bus_port_dma_requests_tb;
    logic        clk_in;
    logic        nrst_in;
    logic [3:0]  av_a;
    logic        av_r;
    logic        av_w;
    logic [31:0] av_wd;
    logic [31:0] av_rd;
    logic        av_wait;
    logic        irq_ev;
    logic        m_start;
    logic        o_load;
    logic [31:0] o_word;
    logic        i_take;
    logic [31:0] i_word;
    logic        i_full;
    logic [31:0] m_word;
    logic        ack_d;
    logic        m_valid;
    int          nm;
    logic [31:0] q;
    logic [31:0] w;
    logic [31:0] exp_m;
    logic        h;
    logic        l;
    int          n_errors;
    int          n_checks;
    int          acks;
    int          n0;
    hbp_if link_if ();

    hbp_host #(.CLK_DIV(4)) hbp_host_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(av_a), .avs_read_in(av_r),
        .avs_write_in(av_w), .avs_writedata_in(av_wd), .avs_readdata_out(av_rd),
        .avs_waitrequest_out(av_wait), .link(link_if.host));
    hbp_device hbp_device_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .link(link_if.device), .irq_event_in(irq_ev),
        .maint_start_in(m_start), .cell_out_load_in(o_load), .cell_out_word_in(o_word),
        .cell_in_full_out(i_full), .cell_in_word_out(i_word), .cell_in_take_in(i_take),
        .maint_word_out(m_word), .maint_word_out_valid_out(m_valid));
    hbp_properties hbp_properties_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .bus_clk(link_if.bus_clk),
        .host_select_n(link_if.host_select_n), .host_read_not_write(link_if.host_read_not_write),
        .host_data_oe(link_if.host_data_oe), .dev_data_oe(link_if.dev_data_oe),
        .ack_out(link_if.ack_out), .ack_oe(link_if.ack_oe), .host_irq_out(link_if.host_irq_out),
        .dma_req(link_if.dma_req), .irq_event_in(irq_ev));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // counts ack pulses seen on the wire
    always @(posedge clk_in) begin
        ack_d <= link_if.ack_oe[0];
        if (link_if.ack_oe[0] && !ack_d) acks++;
        if (m_valid === 1'b1) nm++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tmo(input int n, input int lim);
        if (n >= lim) begin
            n_errors++;
            $display("mismatch at %0t: wait timed out", $time);
            wrap_up();
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic av(input logic r, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] rq);
        int n;
        @(posedge clk_in);
        av_a <= a;
        av_r <= r;
        av_w <= !r;
        av_wd <= d;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (av_wait !== 1'b0 && n < 100);
        // read data stands at the edge where wait is low
        rq = av_rd;
        tmo(n, 100);
        av_r <= 1'b0;
        av_w <= 1'b0;
    endtask
    task automatic acc(input logic r, input logic [7:0] idx, input logic [31:0] d,
                       input logic wh, input logic wl, output logic [31:0] rq);
        int n;
        av(1'b0, `HBP_AV_ADDR, {22'h0, idx, 2'h0}, rq);
        av(1'b0, `HBP_AV_WDATA, d, rq);
        av(1'b0, `HBP_AV_CMD, {29'h0, wl, wh, r}, rq);
        n = 0;
        do begin
            av(1'b1, `HBP_AV_STATUS, 32'h0, rq);
            n++;
        end while (rq[0] !== 1'b0 && n < 200);
        tmo(n, 200);
        if (r) av(1'b1, `HBP_AV_RDATA, 32'h0, rq);
    endtask
    function automatic logic [31:0] cfgv(input logic [5:0] sel, input logic [3:0] lo);
        return {4'h0, 8'h01, 8'h04, 2'h0, sel, lo};
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic m, input logic od, input logic wh,
                                          input logic wl);
        logic up;
        logic dn;
        up = m ? (!wl || wh == od) : !wh;
        dn = m ? (!wl || wh != od) : !wl;
        return {up ? n[31:16] : o[31:16], dn ? n[15:0] : o[15:0]};
    endfunction

    initial begin
        nrst_in = 1'b0;
        {av_a, av_r, av_w, av_wd} = '0;
        {irq_ev, m_start, o_load, o_word, i_take} = '0;
        q = $urandom(32'h269461d6);
        idle(16);
        nrst_in <= 1'b1;
        acc(1'b1, `HBP_IDX_CONFIG, 32'h0, q[0], q[1], q);
        chk({26'h0, q[9:4]}, 32'h24);
        idle(24);
        chk({29'h0, link_if.dma_req}, 32'h1);
        acc(1'b1, 8'h20, 32'h0, 1'b1, 1'b1, q);
        chk(q, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            n0 = acks;
            acc(1'b0, `HBP_IDX_CELL_IN, w, 1'b0, 1'b0, q);
            idle(24);
            chk(acks - n0, 1);
            chk(i_word, w);
            chk({31'h0, i_full}, 32'h1);
            chk({29'h0, link_if.dma_req}, 32'h0);
            @(posedge clk_in);
            i_take <= 1'b1;
            @(posedge clk_in);
            i_take <= 1'b0;
            idle(24);
            chk({29'h0, link_if.dma_req}, 32'h1);
            o_word <= w ^ 32'h5a5a_0f0f;
            o_load <= 1'b1;
            @(posedge clk_in);
            o_load <= 1'b0;
            idle(24);
            chk({29'h0, link_if.dma_req}, 32'h3);
            acc(1'b1, `HBP_IDX_CELL_OUT, 32'h0, w[0], w[1], q);
            chk(q, w ^ 32'h5a5a_0f0f);
            idle(24);
            chk({29'h0, link_if.dma_req}, 32'h1);
        end
        $display("cell test done");
        acc(1'b0, `HBP_IDX_CONFIG, cfgv(6'h31, 4'h0), 1'b0, 1'b0, q);
        idle(24);
        chk({29'h0, link_if.dma_req}, 32'h2);
        acc(1'b0, `HBP_IDX_CONFIG, cfgv(6'h24, 4'h0), 1'b0, 1'b0, q);
        @(posedge clk_in);
        m_start <= 1'b1;
        @(posedge clk_in);
        m_start <= 1'b0;
        idle(24);
        chk({29'h0, link_if.dma_req}, 32'h5);
        exp_m = $urandom;
        acc(1'b0, `HBP_IDX_MAINT_DATA, exp_m, 1'b0, 1'b0, q);
        idle(24);
        chk({29'h0, link_if.dma_req}, 32'h1);
        chk(m_word, exp_m);
        chk(nm, 1);
        $display("request test done");
        for (int i = 0; i < 9; i++) begin
            w = $urandom;
            l = (i / 3 == 0) ? (i % 3 == 1) : (i % 3 != 0);
            h = (i / 3 == 0) ? (i % 3 == 2) : (i % 3 == 0 ? w[0] : (i % 3 == 1) == (i / 3 == 2));
            acc(1'b0, `HBP_IDX_CONFIG, cfgv(6'h24, {2'b0, i / 3 == 2, i / 3 != 0}), 1'b0,
                1'b0, q);
            acc(1'b0, `HBP_IDX_MAINT_DATA, w, h, l, q);
            exp_m = merge(exp_m, w, i / 3 != 0, i / 3 == 2, h, l);
            idle(4);
            chk(m_word, exp_m);
        end
        chk(nm, 10);
        $display("lane test done");
        @(posedge clk_in);
        irq_ev <= 1'b1;
        @(posedge clk_in);
        irq_ev <= 1'b0;
        idle(4);
        chk({31'h0, link_if.host_irq_out}, 32'h1);
        acc(1'b1, `HBP_IDX_IRQ, 32'h0, 1'b1, 1'b1, q);
        chk(q, 32'h1);
        idle(4);
        chk({31'h0, link_if.host_irq_out}, 32'h0);
        acc(1'b0, `HBP_IDX_CONFIG, cfgv(6'h24, 4'h4), 1'b0, 1'b0, q);
        n0 = acks;
        acc(1'b0, `HBP_IDX_CELL_IN, 32'h0, 1'b0, 1'b0, q);
        idle(24);
        chk(acks - n0, 0);
        acc(1'b1, `HBP_IDX_STATUS, 32'h0, 1'b1, 1'b1, q);
        idle(24);
        chk(acks - n0, 1);
        $display("ack test done");
        wrap_up();
    end
endmodule // host_bus_port_dma_requests_tb
